/* verilog/icbr_cfg.svh */
// Constants of the serial bit-rate and hold-timing generator.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ICBR_CFG_SVH
`define ICBR_CFG_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define ICBR_OFS_DIVIDER   8'h00
`define ICBR_OFS_CONTROL   8'h04
`define ICBR_OFS_STATUS    8'h08
`define ICBR_ADDR_MSB      7
`define ICBR_DIVIDER_RST   8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ICBR_RATE_MULTIPLIER_SELECT_HI       7
`define ICBR_RATE_MULTIPLIER_SELECT_LO       6
`define ICBR_ICR_HI        5
`define ICBR_ICR_LO        0
`define ICBR_CTL_START     0
`define ICBR_CTL_STOP      1
`define ICBR_CTL_BIT       2
`define ICBR_CTL_VALUE     3
`define ICBR_ST_BUSY       0
`define ICBR_ST_BUS_BUSY   1
`define ICBR_ST_REFUSED    2
`define ICBR_ST_RX_BIT     3
`define ICBR_ST_BAD_RATE_MULTIPLIER_SELECT   4

// ----------------------------------------------------------------------
// Multiplier codes and timing widths
// ----------------------------------------------------------------------
`define ICBR_RATE_MULTIPLIER_SELECT_X1       2'h0
`define ICBR_RATE_MULTIPLIER_SELECT_X2       2'h1
`define ICBR_RATE_MULTIPLIER_SELECT_X4       2'h2
`define ICBR_RATE_MULTIPLIER_SELECT_RSVD     2'h3
`define ICBR_CNT_W         12
`define ICBR_PRE_W         2
`define ICBR_HTRANS_NONSEQ 2'h2

`endif

/* verilog/icbr_pkg.sv */
// Types shared by the bit-rate and hold-timing generator.
// Assumes icbr_cfg.svh on the include path.
`include "icbr_cfg.svh"

package icbr_pkg;

    // One row of the clock-rate table, counts in multiplier ticks
    typedef struct packed {
        logic [`ICBR_CNT_W-1:0] divider;
        logic [`ICBR_CNT_W-1:0] sda_hold;
        logic [`ICBR_CNT_W-1:0] start_hold;
        logic [`ICBR_CNT_W-1:0] stop_hold;
    } icbr_timing_t;

    typedef enum logic [2:0] {
        ICBR_IDLE,
        ICBR_START_HOLD,
        ICBR_HELD,
        ICBR_BIT_LOW,
        ICBR_BIT_HIGH,
        ICBR_STOP_LOW,
        ICBR_STOP_HOLD
    } icbr_state_t;

endpackage

/* verilog/icbr_timing.sv */
// Bit-rate and hold-timing generator with its AHB-Lite register slave.
// Assumes open-drain serial pins resolved outside; pin inputs are async.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`include "icbr_cfg.svh"

// Summary of operation
// - Top two divider bits pick factor 1, 2 or 4; code 11 reserved.
// - Low six divider bits index divider and three hold values.
// - Bit rate is bus clock over multiplier times selected divider.
// - Data stays put for bus period x multiplier x data-hold after clock falls.
// - After start, wait period x multiplier x start-hold, then clock low.
// - For stop, clock rises, wait stop-hold time, then data rises.
// - Start is data falling while clock high, only when bus is free.
module icbr_timing
    import icbr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    // ------------------------------------------------------------------
    // Clock-rate table
    // ------------------------------------------------------------------
    // Known rows are fixed; the rest follow a linear fill until the full
    // table is loaded here.
    function automatic icbr_timing_t rate_row(input logic [5:0] clock_rate_index);
        icbr_timing_t r;
        r.divider    = 12'h014 + {4'h0, clock_rate_index, 2'b00};
        r.sda_hold   = r.divider >> 2;
        r.start_hold = (r.divider >> 1) - 12'h004;
        r.stop_hold  = (r.divider >> 1) + 12'h001;
        unique case (clock_rate_index)
            6'h00:   r = '{12'h014, 12'h007, 12'h006, 12'h00b};
            6'h07:   r = '{12'h028, 12'h00a, 12'h010, 12'h015};
            6'h0b:   r = '{12'h028, 12'h009, 12'h010, 12'h015};
            6'h14:   r = '{12'h050, 12'h011, 12'h022, 12'h029};
            6'h18:   r = '{12'h050, 12'h009, 12'h026, 12'h029};
            default: r = r;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Registers and bus slave
    // ------------------------------------------------------------------
    logic [7:0]               serial_clock_divider;
    logic                     wr_pend;
    logic [`ICBR_ADDR_MSB:0]  wr_addr;
    logic                     cmd_start;
    logic                     cmd_stop;
    logic                     cmd_bit;
    logic                     cmd_value;
    logic                     refused;
    logic                     rx_bit;
    logic                     bus_busy;
    icbr_state_t              state;
    logic                     addr_ok;
    logic                     ctl_wr;

    assign addr_ok = hsel && hready && htrans[1];
    assign ctl_wr  = wr_pend && (wr_addr == `ICBR_OFS_CONTROL);

    // Slave holds hreadyout low in reset and high from the first clock after; always answers OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[`ICBR_ADDR_MSB:0];
        end
    end

    // Read data registered in the address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr[`ICBR_ADDR_MSB:0])
                `ICBR_OFS_DIVIDER: hrdata <= {24'h0, serial_clock_divider};
                `ICBR_OFS_STATUS:  hrdata <= {27'h0,
                    serial_clock_divider[`ICBR_RATE_MULTIPLIER_SELECT_HI:`ICBR_RATE_MULTIPLIER_SELECT_LO] == `ICBR_RATE_MULTIPLIER_SELECT_RSVD,
                    rx_bit, refused, bus_busy, state != ICBR_IDLE && state != ICBR_HELD};
                default:           hrdata <= '0;
            endcase
        end
    end

    // Divider register written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_clock_divider <= `ICBR_DIVIDER_RST;
        end else if (wr_pend && wr_addr == `ICBR_OFS_DIVIDER) begin
            serial_clock_divider <= hwdata[7:0];
        end
    end

    // Command strobes, one cycle each; cmd_value copies hwdata every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_start <= 1'b0;
            cmd_stop  <= 1'b0;
            cmd_bit   <= 1'b0;
            cmd_value <= 1'b0;
        end else begin
            cmd_start <= ctl_wr && hwdata[`ICBR_CTL_START];
            cmd_stop  <= ctl_wr && hwdata[`ICBR_CTL_STOP];
            cmd_bit   <= ctl_wr && hwdata[`ICBR_CTL_BIT];
            cmd_value <= hwdata[`ICBR_CTL_VALUE];
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and bus-free tracking
    // ------------------------------------------------------------------
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       sda_prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            sda_prev <= sda_sync[1];
        end
    end

    // Start seen on the wire marks busy, stop frees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_busy <= 1'b0;
        end else if (scl_sync[1] && sda_prev && !sda_sync[1]) begin
            bus_busy <= 1'b1;
        end else if (scl_sync[1] && !sda_prev && sda_sync[1]) begin
            bus_busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Multiplier prescaler
    // ------------------------------------------------------------------
    logic [`ICBR_PRE_W-1:0] pre_cnt;
    logic [`ICBR_PRE_W-1:0] pre_top;
    logic                   tick;
    icbr_timing_t           row;

    // Reserved code runs as factor 4 so timing stays slow and safe
    always_comb begin
        unique case (serial_clock_divider[`ICBR_RATE_MULTIPLIER_SELECT_HI:`ICBR_RATE_MULTIPLIER_SELECT_LO])
            `ICBR_RATE_MULTIPLIER_SELECT_X1: pre_top = 2'h0;
            `ICBR_RATE_MULTIPLIER_SELECT_X2: pre_top = 2'h1;
            default:       pre_top = 2'h3;
        endcase
    end

    assign tick = (pre_cnt == pre_top);
    assign row  = rate_row(serial_clock_divider[`ICBR_ICR_HI:`ICBR_ICR_LO]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt <= '0;
        end else if (tick || state == ICBR_IDLE || state == ICBR_HELD) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Serial sequencer
    // ------------------------------------------------------------------
    logic [`ICBR_CNT_W-1:0] cnt;
    logic [`ICBR_CNT_W-1:0] half;
    logic                   bit_value;
    logic                   refuse;

    assign half   = row.divider >> 1;
    assign refuse = cmd_start && (bus_busy || state != ICBR_IDLE);

    // Tick counter spans both clock halves; cleared only while parked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
        end else if (state == ICBR_IDLE || state == ICBR_HELD) begin
            cnt <= '0;
        end else if (tick) begin
            cnt <= cnt + 12'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= ICBR_IDLE;
            scl_oe    <= 1'b0;
            sda_oe    <= 1'b0;
            bit_value <= 1'b1;
            rx_bit    <= 1'b0;
        end else begin
            unique case (state)
                ICBR_IDLE: if (cmd_start && !refuse) begin
                    sda_oe <= 1'b1;
                    state  <= ICBR_START_HOLD;
                end
                ICBR_START_HOLD: if (tick && cnt == row.start_hold - 12'h001) begin
                    scl_oe <= 1'b1;
                    state  <= ICBR_HELD;
                end
                ICBR_HELD: if (cmd_bit) begin
                    bit_value <= cmd_value;
                    state     <= ICBR_BIT_LOW;
                end else if (cmd_stop) begin
                    state <= ICBR_STOP_LOW;
                end
                ICBR_BIT_LOW: if (tick) begin
                    if (cnt == row.sda_hold - 12'h001) begin
                        sda_oe <= !bit_value;
                    end
                    if (cnt == half - 12'h001) begin
                        scl_oe <= 1'b0;
                        state  <= ICBR_BIT_HIGH;
                    end
                end
                ICBR_BIT_HIGH: if (tick && cnt == row.divider - 12'h001) begin
                    rx_bit <= sda_sync[1];
                    scl_oe <= 1'b1;
                    state  <= ICBR_HELD;
                end
                ICBR_STOP_LOW: if (tick) begin
                    if (cnt == row.sda_hold - 12'h001) begin
                        sda_oe <= 1'b1;
                    end
                    if (cnt == half - 12'h001) begin
                        scl_oe <= 1'b0;
                        state  <= ICBR_STOP_HOLD;
                    end
                end
                ICBR_STOP_HOLD: if (tick && cnt == half + row.stop_hold - 12'h001) begin
                    sda_oe <= 1'b0;
                    state  <= ICBR_IDLE;
                end
            endcase
        end
    end

    // Refused start is sticky; a new refusal wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refused <= 1'b0;
        end else if (refuse) begin
            refused <= 1'b1;
        end else if (wr_pend && wr_addr == `ICBR_OFS_STATUS && hwdata[`ICBR_ST_REFUSED]) begin
            refused <= 1'b0;
        end
    end

    // Open-drain pins only ever drive low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

endmodule // icbr_timing

/* verif/icbr_peer.sv */
// Model of the other parties on the two-wire bus: pull-ups, a slave
// that pulls data low on command, and a foreign master start/stop.
module icbr_peer (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic scl_oe,
    input  wire logic scl_out,
    input  wire logic sda_oe,
    input  wire logic sda_out,
    input  wire logic ack_en,
    input  wire logic slow,
    input  wire logic ext_start,
    input  wire logic ext_stop,
    output logic      scl_w,
    output logic      sda_w
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       pull;
    logic [1:0] lag;

    // Released wires float high through the pull-ups
    assign scl_w = scl_oe ? scl_out : 1'b1;
    assign sda_w = (sda_oe ? sda_out : 1'b1) & !pull;

    // Slave data only moves while the clock wire is low, else it would frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pull <= 1'b0;
            lag  <= 2'h0;
        end else if (ext_start && scl_w && sda_w) begin
            pull <= 1'b1;
        end else if (ext_stop && scl_w) begin
            pull <= 1'b0;
        end else if (!scl_w && pull != ack_en) begin
            lag <= lag + 2'h1;
            if (!slow || lag == 2'h3) begin
                pull <= ack_en;
            end
        end
    end
endmodule // icbr_peer

/* verif/icbr_timing_assertions.sv */
// Timing checker; snoops the divider write to know the expected counts.
// Assumes it is bound to icbr_timing and sees only its ports.
module icbr_timing_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        scl_oe,
    input wire logic        sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] div_q;
    logic [7:0] a_a;
    logic       a_v, a_w, p_scl, p_sda, in_st, busy_w, p_si, p_di;
    int         m, dv, sdh, sth, sph, cnt, cnt_s;

    // Factor and table row of the current divider setting
    always_comb begin
        m = (div_q[7:6] == 2'h0) ? 1 : (div_q[7:6] == 2'h1) ? 2 : 4;
        case (div_q[5:0])
            6'h00: begin dv = 20; sdh = 7; sth = 6; sph = 11; end
            6'h07: begin dv = 40; sdh = 10; sth = 16; sph = 21; end
            6'h0b: begin dv = 40; sdh = 9; sth = 16; sph = 21; end
            6'h14: begin dv = 80; sdh = 17; sth = 34; sph = 41; end
            6'h18: begin dv = 80; sdh = 9; sth = 38; sph = 41; end
            default: begin
                dv  = 20 + 4 * div_q[5:0];
                sdh = dv / 4;
                sth = dv / 2 - 4;
                sph = dv / 2 + 1;
            end
        endcase
    end

    // Bus snoop, pin-edge counters and a wire-level busy flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {div_q, a_a, a_v, a_w} <= 18'h0;
            {p_scl, p_sda, in_st, busy_w, p_si, p_di} <= 6'h3;
            cnt   <= 0;
            cnt_s <= 0;
        end else begin
            if (hready) begin
                a_v <= hsel && htrans[1];
                a_w <= hwrite;
                a_a <= haddr[7:0];
                if (a_v && a_w && a_a == 8'h00) div_q <= hwdata[7:0];
            end
            p_scl <= scl_oe;
            p_sda <= sda_oe;
            cnt   <= (scl_oe != p_scl || sda_oe != p_sda) ? 1 : cnt + 1;
            cnt_s <= (scl_oe != p_scl) ? 1 : cnt_s + 1;
            if (sda_oe && !p_sda && !scl_oe) in_st <= 1'b1;
            else if (scl_oe) in_st <= 1'b0;
            p_si <= scl_in;
            p_di <= sda_in;
            if (scl_in && p_si && p_di && !sda_in) busy_w <= 1'b1;
            else if (scl_in && p_si && !p_di && sda_in) busy_w <= 1'b0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd(logic [7:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a ##1 hready;
    endsequence

    chk_start_hold: assert property ($rose(scl_oe) && in_st |-> cnt == sth * m)
        else $error("start hold count wrong");
    chk_stop_hold: assert property ($fell(sda_oe) && !scl_oe |-> cnt == sph * m)
        else $error("stop hold count wrong");
    chk_high_half: assert property ($rose(scl_oe) && !in_st |-> cnt_s == (dv - dv/2) * m)
        else $error("clock high time wrong");
    chk_low_half: assert property ($fell(scl_oe) |-> cnt_s >= (dv / 2) * m)
        else $error("clock low time short");
    chk_data_hold: assert property ($changed(sda_oe) && $stable(scl_oe) && scl_oe
        |-> cnt_s >= sdh * m)
        else $error("data moved too soon");
    chk_start_free: assert property ($rose(sda_oe) && !scl_oe |-> !busy_w)
        else $error("start on busy bus");
    chk_div_read: assert property (s_rd(8'h00) |-> hrdata == {24'h0, div_q})
        else $error("divider readback wrong");
    chk_rate_multiplier_select_flag: assert property (s_rd(8'h08) |-> hrdata[4] == (div_q[7:6] == 2'h3))
        else $error("reserved factor flag wrong");
endmodule // icbr_timing_checker

bind icbr_timing icbr_timing_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe));

/* verif/i2c_bit_rate_and_hold_timing_bench.sv */
// Self-checking bench: register access, start/bit/stop runs, refusal.
// Assumes icbr_peer as the bus partner and the bound timing checker.
module i2c_bit_rate_and_hold_timing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, wv;
    logic [1:0]  htrans;
    logic        scl_w, sda_w, scl_out, scl_oe, sda_out, sda_oe;
    logic        ack_en, slow, ext_start, ext_stop;
    logic [7:0]  cfg [8];
    int          fail_count, n_compared, i;

    icbr_timing i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
    icbr_peer i_peer (.hclk(hclk), .hresetn(hresetn), .scl_oe(scl_oe), .scl_out(scl_out),
        .sda_oe(sda_oe), .sda_out(sda_out), .ack_en(ack_en), .slow(slow),
        .ext_start(ext_start), .ext_stop(ext_stop), .scl_w(scl_w), .sda_w(sda_w));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One single AHB transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Issue a command, poll busy, then leave settled status in rd
    task automatic cmd(input logic [3:0] c);
        int k;
        ahb(1'b1, 8'h04, {28'h0, c});
        repeat (4) @(posedge hclk);
        k = 0;
        do begin
            ahb(1'b0, 8'h08, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 3000);
        chk("busy", 0, rd[0]);
        repeat (4) @(posedge hclk);
        ahb(1'b0, 8'h08, 32'h0);
    endtask

    function automatic logic rx_exp(input logic v, input logic a);
        return v & !a;
    endfunction

    task automatic run(input logic [7:0] cf, input logic v, input logic a);
        ahb(1'b1, 8'h00, {24'h0, cf});
        ahb(1'b0, 8'h08, 32'h0);
        chk("reserved flag", cf[7:6] == 2'h3, rd[4]);
        cmd(4'h1);
        chk("held", 2'b11, {scl_oe, sda_oe});
        chk("bus busy", 1, rd[1]);
        ack_en <= a;
        slow   <= 1'($urandom);
        cmd({v, 3'b100});
        chk("rx first", rx_exp(v, a), rd[3]);
        ack_en <= 1'b0;
        cmd({!v, 3'b100});
        chk("rx second", !v, rd[3]);
        cmd(4'h2);
        chk("released", 0, {scl_oe, sda_oe, rd[1]});
    endtask

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        {hresetn, hsel, hwrite, htrans, ack_en, slow, ext_start, ext_stop} = 9'h0;
        haddr      = 32'h0;
        hwdata     = 32'h0;
        fail_count = 0;
        n_compared = 0;
        i = $urandom(32'h2b38fbc7);
        cfg = '{8'h80, 8'h47, 8'h4b, 8'h14, 8'h18, 8'hc0, 8'h00, 8'h00};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        ahb(1'b0, 8'h00, 32'h0);
        chk("divider reset", 0, rd);
        ahb(1'b0, 8'h08, 32'h0);
        chk("status reset", 0, rd);
        // Keep the written word aside: the read's data phase overwrites hwdata
        for (i = 0; i < 6; i++) begin
            wv = $urandom;
            ahb(1'b1, 8'h00, wv);
            ahb(1'b0, 8'h00, 32'h0);
            chk("divider", {24'h0, wv[7:0]}, rd);
        end
        ahb(1'b1, 8'h0c, 32'hffffffff);
        ahb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 0, rd);
        ahb(1'b0, 8'h04, 32'h0);
        chk("control read", 0, rd);
        cmd(4'hc);
        chk("bit when idle", {27'h0, wv[7:6] == 2'h3, 4'h0}, rd);
        chk("idle pins", 0, {scl_oe, sda_oe});
        cfg[6] = 8'($urandom);
        cfg[7] = 8'($urandom);
        for (i = 0; i < 8; i++) run(cfg[i], 1'($urandom), i[0]);
        ext_start <= 1'b1;
        @(posedge hclk);
        ext_start <= 1'b0;
        // Let the foreign start pass the pin synchronisers first
        repeat (4) @(posedge hclk);
        cmd(4'h1);
        chk("refused", {27'h0, cfg[7][7:6] == 2'h3, 4'h6},
            {rd[31:4], rd[3] & 1'b0, rd[2:0]});
        chk("no start", 0, {scl_oe, sda_oe});
        ahb(1'b1, 8'h08, 32'h4);
        ahb(1'b0, 8'h08, 32'h0);
        chk("refusal cleared", 0, rd[2]);
        ext_stop <= 1'b1;
        @(posedge hclk);
        ext_stop <= 1'b0;
        repeat (8) @(posedge hclk);
        ahb(1'b0, 8'h08, 32'h0);
        chk("bus free", 0, rd[1]);
        tally_and_finish;
    end

    // Watchdog well beyond the longest expected run
    initial begin
        #300000;
        fail_count++;
        tally_and_finish;
    end
endmodule // i2c_bit_rate_and_hold_timing_bench
